// [shared/twi_pkg.sv]
// shared constants for the two-wire register port and its master
package twi_pkg;
    localparam logic [6:0] slave_addr = 7'h33;
    localparam logic [7:0] reg_chip_ctrl = 8'h00;
    localparam int chip_en_bit = 6;
    localparam logic [7:0] chip_ctrl_reset = 8'h00;
    localparam int sys_clk_mhz = 40;
    localparam int link_period_ns = 200;
    // master takes one step per quarter bit period (scl edges on every second step), at least one cycle
    localparam int quarter_ns = link_period_ns / 4;
    localparam int quarter_cycles =
        (quarter_ns * sys_clk_mhz / 1000) < 1 ? 1 : (quarter_ns * sys_clk_mhz / 1000);
    localparam logic [7:0] quarter_count = 8'(quarter_cycles);
    localparam int num_regs = 256;
    // master register bank offsets
    localparam logic [3:0] off_ctrl = 4'h0;
    localparam logic [3:0] off_addr = 4'h4;
    localparam logic [3:0] off_wdata = 4'h8;
    localparam logic [3:0] off_status = 4'hc;
    localparam int ctrl_go_bit = 0;
    localparam int ctrl_read_bit = 1;
    localparam int stat_busy_bit = 0;
    localparam int stat_nack_bit = 1;
endpackage

// [shared/twi_if.sv]
// two-wire link between master and register slave, open-drain resolved here
`timescale 1ns/1ps
interface twi_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    wire scl_i;
    wire sda_i;
    // pull-ups: a line is low only while some end drives low
    assign scl_i = !(scl_oe && !scl_o);
    assign sda_i = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
    modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe,
        input scl_i, input sda_i);
    modport slave (output sda_s_o, output sda_s_oe, input scl_i, input sda_i);
endinterface

// [rtl/twi_reg_slave.sv]
// two-wire slave port giving the bus master access to the register file
// Behaviour
// - data changes only while clock low
// - sda falling with scl high is start
// - sda rising with scl high is stop
// - only master makes start and stop
// - bus busy from start to stop
// - repeated start acts as start
// - eight bits msb first plus ack
// - slave pulls sda low on ninth clock
// - acknowledge every received byte
// - master leaves last read byte unacknowledged
// - first byte: address and direction bit
// - answer only address 33 hex
// - second byte register, third byte data
// - read preceded by address write
// - index increments after each written byte
// - index never increments on read
// - external clock pin unused for transfers
// - register 00 bit 6 chip enable
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module twi_reg_slave
(
    input wire logic sys_clk,
    input wire logic rst_n,
    twi_if.slave link,
    input wire logic ext_clk,
    output logic chip_enable,
    output logic bus_busy
);
    import twi_pkg::*;

    typedef enum logic [2:0] {idle_st, addr_st, reg_st, wdata_st, rdata_st, ack_st,
        mack_st} state_type;

    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic scl_reg;
    logic sda_reg;
    state_type state_reg;
    state_type after_ack_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] index_reg;
    logic rx_count_reg;
    logic sda_oe_reg;
    logic busy_reg;
    logic [7:0] regs [num_regs];

    // ext_clk is deliberately unconnected to any logic: transfers use scl only
    wire ext_clk_unused = ext_clk;
    wire scl_s = scl_sync_reg[1];
    wire sda_s = sda_sync_reg[1];
    wire scl_rise = scl_s && !scl_reg;
    wire scl_fall = !scl_s && scl_reg;
    wire start_det = scl_s && scl_reg && sda_reg && !sda_s;
    wire stop_det = scl_s && scl_reg && !sda_reg && sda_s;
    wire [7:0] byte_in = {shift_reg[6:0], sda_s};
    // the whole byte already sits in shift_reg when the ack decision is taken
    wire addr_match = shift_reg[7:1] == slave_addr;
    wire [7:0] rd_byte = regs[index_reg];
    // a byte is complete on the scl fall after the eighth rising edge
    wire byte_done = scl_fall && bit_cnt_reg == 3'h0 && rx_count_reg
        && (state_reg == addr_st || state_reg == reg_st || state_reg == wdata_st);

    assign link.sda_s_o = 1'b0;
    assign link.sda_s_oe = sda_oe_reg;
    assign chip_enable = regs[reg_chip_ctrl][chip_en_bit];
    assign bus_busy = busy_reg;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
        end
        else
        begin
            scl_sync_reg <= {scl_sync_reg[0], link.scl_i};
            sda_sync_reg <= {sda_sync_reg[0], link.sda_i};
            scl_reg <= scl_s;
            sda_reg <= sda_s;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            busy_reg <= 1'b0;
        else if (start_det)
            busy_reg <= 1'b1;
        else if (stop_det)
            busy_reg <= 1'b0;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= idle_st;
            after_ack_reg <= idle_st;
            bit_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
            index_reg <= 8'h00;
            sda_oe_reg <= 1'b0;
            for (int i = 0; i < num_regs; i++)
                regs[i] <= chip_ctrl_reset;
        end
        else if (start_det)
        begin
            // repeated start is the same as a first start
            state_reg <= addr_st;
            bit_cnt_reg <= 3'h0;
            sda_oe_reg <= 1'b0;
        end
        else if (stop_det)
        begin
            state_reg <= idle_st;
            sda_oe_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                idle_st:
                    sda_oe_reg <= 1'b0;
                addr_st, reg_st, wdata_st:
                    if (scl_rise)
                    begin
                        shift_reg <= byte_in;
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    end
                ack_st:
                    if (scl_fall)
                    begin
                        // ninth clock done: release and move on
                        sda_oe_reg <= 1'b0;
                        state_reg <= after_ack_reg;
                        bit_cnt_reg <= 3'h0;
                        if (after_ack_reg == rdata_st)
                            sda_oe_reg <= !rd_byte[7];
                        shift_reg <= rd_byte;
                    end
                rdata_st:
                    if (scl_fall)
                    begin
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        if (bit_cnt_reg == 3'h7)
                        begin
                            sda_oe_reg <= 1'b0;
                            state_reg <= mack_st;
                        end
                        else
                            sda_oe_reg <= !shift_reg[6];
                    end
                mack_st:
                    if (scl_rise)
                    begin
                        // unacknowledged byte ends data; an ack resends the same register
                        state_reg <= sda_s ? idle_st : ack_st;
                        after_ack_reg <= rdata_st;
                    end
                default:
                    state_reg <= idle_st;
            endcase
            if (byte_done)
            begin
                sda_oe_reg <= 1'b1;
                state_reg <= ack_st;
                bit_cnt_reg <= 3'h0;
                case (state_reg)
                    addr_st:
                        if (!addr_match)
                        begin
                            sda_oe_reg <= 1'b0;
                            state_reg <= idle_st;
                        end
                        else
                        begin
                            after_ack_reg <= shift_reg[0] ? rdata_st : reg_st;
                        end
                    reg_st:
                    begin
                        index_reg <= shift_reg;
                        after_ack_reg <= wdata_st;
                    end
                    wdata_st:
                    begin
                        regs[index_reg] <= shift_reg;
                        index_reg <= index_reg + 8'h01;
                        after_ack_reg <= wdata_st;
                    end
                    default:
                        after_ack_reg <= idle_st;
                endcase
            end
        end
    end

    // marks the eighth rise so a fall right after a start is never taken as a byte
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rx_count_reg <= 1'b0;
        else if (start_det || stop_det || byte_done)
            rx_count_reg <= 1'b0;
        else if (scl_rise && bit_cnt_reg == 3'h7)
            rx_count_reg <= 1'b1;
    end
endmodule

// [rtl/twi_master.sv]
// two-wire bus master commanded over classic wishbone registers
`timescale 1ns/1ps
module twi_master
(
    input wire logic sys_clk,
    input wire logic rst_n,
    twi_if.master link,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    import twi_pkg::*;

    typedef enum logic [2:0] {idle_st, start_st, bit_st, stop_st, rstart_st}
        state_type;

    logic [1:0] sda_sync_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [7:0] addr_reg;
    logic [7:0] wdata_reg;
    logic [7:0] rdata_reg;
    logic read_reg;
    logic busy_reg;
    logic nack_reg;
    state_type state_reg;
    logic [7:0] tick_reg;
    logic [1:0] phase_reg;
    logic [3:0] bit_reg;
    logic [1:0] byte_reg;
    logic [8:0] tx_reg;
    logic scl_reg;
    logic sda_reg;

    wire req = wb_cyc_i && wb_stb_i && !ack_reg;
    // writes land at the edge where the bus master samples ack high
    wire wr = wb_cyc_i && wb_stb_i && ack_reg && wb_we_i && wb_sel_i[0];
    wire go = wr && wb_adr_i == off_ctrl && wb_dat_i[ctrl_go_bit] && !busy_reg;
    wire tick = tick_reg == 8'h00;
    // a write frame ends after its data byte, a read frame after the received byte
    wire last_byte = byte_reg == 2'h3 || (byte_reg == 2'h2 && !read_reg);
    wire [31:0] rd_mux = wb_adr_i == off_addr ? {24'h0, addr_reg}
        : wb_adr_i == off_wdata ? {24'h0, wdata_reg}
        : wb_adr_i == off_status ? {22'h0, rdata_reg, nack_reg, busy_reg}
        : 32'h0;
    wire [8:0] frame_byte = byte_reg == 2'h0 ? {slave_addr, 1'b0, 1'b1}
        : byte_reg == 2'h1 ? {addr_reg, 1'b1}
        : byte_reg == 2'h2 ? (read_reg ? {slave_addr, 1'b1, 1'b1} : {wdata_reg, 1'b1})
        : 9'h1ff;

    assign link.scl_o = 1'b0;
    assign link.scl_oe = !scl_reg;
    assign link.sda_m_o = 1'b0;
    assign link.sda_m_oe = !sda_reg;
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
            addr_reg <= 8'h00;
            wdata_reg <= 8'h00;
            read_reg <= 1'b0;
            sda_sync_reg <= 2'h3;
        end
        else
        begin
            sda_sync_reg <= {sda_sync_reg[0], link.sda_i};
            ack_reg <= req;
            dat_reg <= rd_mux;
            if (wr && wb_adr_i == off_addr)
                addr_reg <= wb_dat_i[7:0];
            if (wr && wb_adr_i == off_wdata)
                wdata_reg <= wb_dat_i[7:0];
            if (go)
                read_reg <= wb_dat_i[ctrl_read_bit];
        end
    end

    // frame: start, slave+w, register, then data or repeated start+r, data, stop
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= idle_st;
            busy_reg <= 1'b0;
            nack_reg <= 1'b0;
            rdata_reg <= 8'h00;
            tick_reg <= 8'h00;
            phase_reg <= 2'h0;
            bit_reg <= 4'h0;
            byte_reg <= 2'h0;
            tx_reg <= 9'h1ff;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
        end
        else
        begin
            tick_reg <= tick ? quarter_count - 8'h01 : tick_reg - 8'h01;
            if (go)
            begin
                busy_reg <= 1'b1;
                nack_reg <= 1'b0;
                state_reg <= start_st;
                phase_reg <= 2'h0;
                byte_reg <= 2'h0;
            end
            else if (tick)
            begin
                phase_reg <= phase_reg + 2'h1;
                case (state_reg)
                    idle_st:
                        phase_reg <= 2'h0;
                    start_st, rstart_st:
                        case (phase_reg)
                            2'h0: sda_reg <= 1'b1;
                            2'h1: scl_reg <= 1'b1;
                            2'h2: sda_reg <= 1'b0;
                            default:
                            begin
                                scl_reg <= 1'b0;
                                state_reg <= bit_st;
                                bit_reg <= 4'h0;
                                tx_reg <= frame_byte;
                            end
                        endcase
                    bit_st:
                        case (phase_reg)
                            2'h0: sda_reg <= tx_reg[8];
                            2'h1: scl_reg <= 1'b1;
                            2'h2:
                                if (bit_reg == 4'h8)
                                    nack_reg <= nack_reg | (sda_sync_reg[1] & !read_recv());
                                else if (read_recv())
                                    rdata_reg <= {rdata_reg[6:0], sda_sync_reg[1]};
                            default:
                            begin
                                scl_reg <= 1'b0;
                                tx_reg <= {tx_reg[7:0], 1'b1};
                                bit_reg <= bit_reg + 4'h1;
                                if (bit_reg == 4'h8)
                                begin
                                    byte_reg <= byte_reg + 2'h1;
                                    bit_reg <= 4'h0;
                                    tx_reg <= next_byte();
                                    if (byte_reg == 2'h1 && read_reg)
                                        state_reg <= rstart_st;
                                    else if (last_byte)
                                        state_reg <= stop_st;
                                end
                            end
                        endcase
                    stop_st:
                        case (phase_reg)
                            2'h0: sda_reg <= 1'b0;
                            2'h1: scl_reg <= 1'b1;
                            2'h2: sda_reg <= 1'b1;
                            default:
                            begin
                                state_reg <= idle_st;
                                busy_reg <= 1'b0;
                            end
                        endcase
                    default:
                        state_reg <= idle_st;
                endcase
            end
        end
    end

    // byte 3 of a read is the data from the slave; its ack slot stays high
    function automatic logic read_recv();
        return read_reg && byte_reg == 2'h3;
    endfunction

    // byte that follows the one just finished; the read data slot sends all ones
    function automatic logic [8:0] next_byte();
        return byte_reg == 2'h0 ? {addr_reg, 1'b1}
            : (byte_reg == 2'h1 ? (read_reg ? {slave_addr, 1'b1, 1'b1} : {wdata_reg, 1'b1})
            : 9'h1ff);
    endfunction
endmodule

// [sim/twi_reg_slave_chk.sv]
// assertions on the two-wire link between the master and the register slave
`timescale 1ns/1ps
module twi_reg_slave_chk
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_s_o,
    input wire logic sda_s_oe,
    input wire logic bus_busy,
    input wire logic chip_enable
);
    logic scl_q;
    logic sda_q;
    logic first_reg;
    logic [3:0] bit_cnt_reg;
    logic [3:0] stop_age_reg;
    wire scl_rise = scl_i && !scl_q;
    wire start_ev = scl_i && scl_q && sda_q && !sda_i;
    wire stop_ev = scl_i && scl_q && !sda_q && sda_i;
    wire ninth = scl_rise && (bit_cnt_reg == 4'h8);
    wire [3:0] bit_cnt_next = start_ev ? 4'h0 : ninth ? 4'h0 : scl_rise ? bit_cnt_reg + 4'h1 :
        bit_cnt_reg;
    wire first_next = start_ev ? 1'b1 : ninth ? 1'b0 : first_reg;
    wire [3:0] stop_age_next = stop_ev ? 4'h0 : (stop_age_reg == 4'hf) ? 4'hf : stop_age_reg + 4'h1;

    // the rise before a start is counted too, the start itself clears the count
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            first_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            stop_age_reg <= 4'hf;
        end
        else
        begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            first_reg <= first_next;
            bit_cnt_reg <= bit_cnt_next;
            stop_age_reg <= stop_age_next;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_sda_high_stable: assert property (scl_i && scl_q |-> $stable(sda_s_oe))
        else $error("slave changed sda while scl high");
    a_start_busy: assert property (start_ev |-> ##[1:4] bus_busy)
        else $error("start not followed by busy");
    a_stop_free: assert property (stop_ev |-> ##[1:4] !bus_busy)
        else $error("stop not followed by free bus");
    a_busy_until_stop: assert property ($fell(bus_busy) |-> stop_age_reg < 4'h6)
        else $error("busy dropped without a stop");
    a_addr_quiet: assert property (scl_rise && first_reg && bit_cnt_reg < 4'h8 |-> !sda_s_oe)
        else $error("slave drove sda inside the address byte");
    a_addr_ack: assert property (ninth && first_reg |-> (sda_s_oe && !sda_s_o) [*3])
        else $error("address byte not acknowledged on ninth clock");
    a_idle_released: assert property (!bus_busy |-> !sda_s_oe)
        else $error("slave drives sda while bus free");
    a_enable_in_frame: assert property ($changed(chip_enable) |-> bus_busy)
        else $error("chip enable changed outside a transfer");
    a_enable_reset: assert property ($rose(rst_n) |-> !chip_enable)
        else $error("chip enable set after reset");

    c_enable: cover property ($rose(chip_enable));
    c_restart: cover property (start_ev && bus_busy);
    c_stop: cover property (stop_ev);
    c_addr_ack: cover property (ninth && first_reg);
endmodule

// [sim/i2c_register_slave_port_test.sv]
// self-checking bench: master and slave back to back, plus a bit-banged second link
`timescale 1ns/1ps
module i2c_register_slave_port_test;
    import twi_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ext_clk = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [3:0] wb_adr = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_rdat;
    logic wb_ack;
    logic chip_enable;
    logic bus_busy;
    logic bus_busy_b;
    logic bb_scl = 1'b1;
    logic bb_sda = 1'b1;
    int err_count = 0;
    int tests_run = 0;

    twi_if link_a();
    twi_if link_b();
    assign link_b.scl_o = 1'b0;
    assign link_b.scl_oe = !bb_scl;
    assign link_b.sda_m_o = 1'b0;
    assign link_b.sda_m_oe = !bb_sda;

    twi_master twi_master_inst(.sys_clk(sys_clk), .rst_n(rst_n), .link(link_a),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'h1), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
    twi_reg_slave twi_reg_slave_inst(.sys_clk(sys_clk), .rst_n(rst_n), .link(link_a),
        .ext_clk(ext_clk), .chip_enable(chip_enable), .bus_busy(bus_busy));
    // second slave keeps its spare clock still, the first sees it toggle
    twi_reg_slave twi_reg_slave_inst_b(.sys_clk(sys_clk), .rst_n(rst_n), .link(link_b),
        .ext_clk(1'b0), .chip_enable(), .bus_busy(bus_busy_b));
    twi_reg_slave_chk twi_reg_slave_chk_inst(.sys_clk(sys_clk), .rst_n(rst_n),
        .scl_i(link_a.scl_i), .sda_i(link_a.sda_i), .sda_s_o(link_a.sda_s_o),
        .sda_s_oe(link_a.sda_s_oe), .bus_busy(bus_busy), .chip_enable(chip_enable));

    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) ext_clk <= ~ext_clk;

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask

    // one classic cycle; entered just after a rising edge
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat,
        output logic [31:0] q);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= dat;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (wb_ack !== 1'b1 && n < 50);
        if (wb_ack !== 1'b1)
        begin
            $display("ERROR wb_ack expected 1 seen %b", wb_ack);
            err_count++;
        end
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic mop(input logic rd, input logic [7:0] ra, input logic [7:0] wd,
        output logic [31:0] st);
        int n;
        logic [31:0] q;
        n = 0;
        wb(1'b1, off_addr, {24'h0, ra}, q);
        wb(1'b1, off_wdata, {24'h0, wd}, q);
        wb(1'b1, off_ctrl, (32'(rd) << ctrl_read_bit) | (32'h1 << ctrl_go_bit), q);
        st = 32'h1;
        while (st[stat_busy_bit] !== 1'b0 && n < 3000)
        begin
            wb(1'b0, off_status, 32'h0, st);
            n++;
        end
        if (st[stat_busy_bit] !== 1'b0)
        begin
            $display("ERROR busy expected 0 seen %b", st[stat_busy_bit]);
            err_count++;
        end
    endtask

    task automatic quarter();
        repeat (quarter_cycles) @(posedge sys_clk);
    endtask

    // leading quarter lets the slave let go of a previous ack first
    task automatic bb_start();
        quarter();
        bb_sda <= 1'b1;
        quarter();
        bb_scl <= 1'b1;
        quarter();
        bb_sda <= 1'b0;
        quarter();
        bb_scl <= 1'b0;
        quarter();
    endtask

    task automatic bb_stop();
        bb_sda <= 1'b0;
        quarter();
        bb_scl <= 1'b1;
        quarter();
        bb_sda <= 1'b1;
        quarter();
        quarter();
    endtask

    task automatic bb_bit(input logic b, output logic s);
        bb_sda <= b;
        quarter();
        bb_scl <= 1'b1;
        quarter();
        s = link_b.sda_i;
        quarter();
        bb_scl <= 1'b0;
        quarter();
    endtask

    task automatic bb_byte(input logic [7:0] d, input logic exp_ack, output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--)
            bb_bit(d[i], q[i]);
        bb_bit(1'b1, a);
        check("ack bit", 32'(exp_ack), 32'(a));
    endtask

    task automatic bb_read(input logic [7:0] ra, input logic [7:0] exp);
        logic [7:0] q;
        bb_start();
        bb_byte({slave_addr, 1'b0}, 1'b0, q);
        bb_byte(ra, 1'b0, q);
        bb_start();
        bb_byte({slave_addr, 1'b1}, 1'b0, q);
        bb_byte(8'hff, 1'b1, q);
        bb_stop();
        check("read data", 32'(exp), 32'(q));
    endtask

    task automatic t_enable();
        logic [31:0] st;
        mop(1'b1, reg_chip_ctrl, 8'h00, st);
        check("reset value", {22'h0, chip_ctrl_reset, 2'b00}, st & 32'h3ff);
        check("chip_enable", 32'h0, 32'(chip_enable));
        mop(1'b0, reg_chip_ctrl, 8'h40, st);
        check("write nack", 32'h0, 32'(st[stat_nack_bit]));
        check("chip_enable", 32'h1, 32'(chip_enable));
        mop(1'b1, reg_chip_ctrl, 8'h00, st);
        check("readback", 32'h40, 32'(st[9:2]));
        mop(1'b0, reg_chip_ctrl, 8'hbf, st);
        check("chip_enable", 32'h0, 32'(chip_enable));
    endtask

    task automatic t_noinc();
        logic [31:0] st;
        mop(1'b0, 8'hff, 8'h5a, st);
        repeat (2)
        begin
            mop(1'b1, 8'hff, 8'h00, st);
            check("repeat read", 32'h5a, 32'(st[9:2]));
        end
    endtask

    task automatic t_autoinc();
        logic [7:0] q;
        logic [7:0] v[3] = '{8'hc1, 8'h2e, 8'h07};
        bb_start();
        check("busy after start", 32'h1, 32'(bus_busy_b));
        bb_byte({slave_addr, 1'b0}, 1'b0, q);
        bb_byte(8'h10, 1'b0, q);
        for (int i = 0; i < 3; i++)
            bb_byte(v[i], 1'b0, q);
        bb_stop();
        check("busy after stop", 32'h0, 32'(bus_busy_b));
        for (int i = 0; i < 3; i++)
            bb_read(8'h10 + 8'(i), v[i]);
    endtask

    task automatic t_foreign();
        logic [7:0] q;
        logic [7:0] ids[4] = '{8'h64, 8'h68, 8'he6, 8'h69};
        for (int i = 0; i < 4; i++)
        begin
            bb_start();
            bb_byte(ids[i], 1'b1, q);
            bb_byte(8'h10, 1'b1, q);
            bb_stop();
        end
        bb_read(8'h10, 8'hc1);
    endtask

    task automatic t_abandon();
        logic [7:0] q;
        logic s;
        bb_start();
        bb_byte({slave_addr, 1'b0}, 1'b0, q);
        bb_byte(8'h20, 1'b0, q);
        repeat (4) bb_bit(1'b1, s);
        bb_start();
        bb_byte({slave_addr, 1'b0}, 1'b0, q);
        bb_byte(8'h21, 1'b0, q);
        bb_byte(8'h77, 1'b0, q);
        bb_stop();
        bb_read(8'h20, 8'h00);
        bb_read(8'h21, 8'h77);
    endtask

    initial
    begin
        repeat (60000) @(posedge sys_clk);
        err_count++;
        $display("ERROR watchdog expected finish seen timeout");
        stop_test();
    end

    initial
    begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_enable();
        t_noinc();
        t_autoinc();
        t_foreign();
        t_abandon();
        stop_test();
    end
endmodule
